// ### verilog/frr_read_path.sv
`timescale 1ns/100ps
`default_nettype none
module frr_read_path
    import frr_pkg::*;
#(
    parameter int FIFO_DEPTH = 16
) (
    // System clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Host pins
    input wire logic cs_n,
    input wire logic sck,
    input wire logic [7:0] dq_i,
    output logic [7:0] dq_o,
    output logic [7:0] dq_oe,
    output logic ds_o,
    output logic ds_oe,
    // Protocol selection
    input wire logic octal_en,
    input wire logic ddr_en,
    // Configuration fields
    input wire logic [7:0] nonvolatile_latency_config,
    input wire logic [7:0] volatile_latency_config,
    input wire logic [2:0] sector_protect_mode_register,
    // Status and protection sources
    input wire logic ready_busy_flag,
    input wire logic [7:1] volatile_status_one,
    input wire logic [7:0] status_two,
    input wire logic protect_lock_bit,
    input wire logic [7:0] dynamic_protection_bit,
    input wire logic [7:0] persistent_protection_bit,
    input wire logic [7:0] ecc_unit_status,
    // Register file lookup
    output logic [ADDR_W-1:0] read_addr,
    output logic read_active,
    input wire logic [7:0] reg_rd_data,
    input wire logic reg_rd_volatile,
    input wire logic reg_rd_password,
    input wire logic reg_rd_protect_access
);
    // ------------------------------------------------------------------
    // Pin synchronisation and edge detection
    // ------------------------------------------------------------------
    localparam int PIN_W = 10;

    logic [PIN_W-1:0] pins_s;
    logic cs_n_s;
    logic sck_s;
    logic [7:0] dq_s;
    logic sck_d_r;
    logic rise;
    logic fall;
    logic edge_any;

    frr_sync #(.W(PIN_W)) u_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .d({cs_n, sck, dq_i}),
        .q(pins_s)
    );

    assign cs_n_s = pins_s[9];
    assign sck_s = pins_s[8];
    assign dq_s = pins_s[7:0];

    // The host clock is only one eighth of ours, so sampling is enough.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sck_d_r <= 1'b0;
        end else begin
            sck_d_r <= sck_s;
        end
    end

    assign rise = !cs_n_s && sck_s && !sck_d_r;
    assign fall = !cs_n_s && !sck_s && sck_d_r;
    assign edge_any = rise || fall;

    // ------------------------------------------------------------------
    // Protocol and byte reception
    // ------------------------------------------------------------------
    frr_proto_t proto;
    frr_state_t state_r;
    frr_kind_t kind_r;
    frr_kind_t kind_nxt;
    logic [2:0] bit_cnt_r;
    logic [7:0] rx_sh_r;
    logic [7:0] op_r;
    logic [1:0] cnt_r;
    logic [1:0] cnt_last;
    logic rx_evt;
    logic [7:0] rx_byte;
    logic rx_phase;
    logic needs_addr;

    always_comb begin
        if (!octal_en) begin
            proto = PROTO_SPI;
        end else if (ddr_en) begin
            proto = PROTO_ODDR;
        end else begin
            proto = PROTO_OSDR;
        end
    end

    assign rx_phase = (state_r == ST_CMD) || (state_r == ST_ADDR);

    always_comb begin
        if (proto == PROTO_SPI) begin
            rx_evt = rx_phase && rise && bit_cnt_r == SINGLE_LAST_BIT;
            rx_byte = {rx_sh_r[6:0], dq_s[0]};
        end else begin
            rx_evt = rx_phase && (rise || (proto == PROTO_ODDR && fall));
            rx_byte = dq_s;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst || cs_n_s) begin
            bit_cnt_r <= 3'h0;
            rx_sh_r <= 8'h00;
        end else if (rx_phase && rise && proto == PROTO_SPI) begin
            bit_cnt_r <= bit_cnt_r + 3'h1;
            rx_sh_r <= rx_byte;
        end
    end

    assign cnt_last = (state_r == ST_ADDR) ? ADDR_LAST :
                      (proto == PROTO_SPI) ? CMD_LAST_SINGLE : CMD_LAST_OCTAL;

    always_ff @(posedge clk_sys) begin
        if (rst || cs_n_s) begin
            cnt_r <= 2'h0;
        end else if (rx_evt) begin
            cnt_r <= (cnt_r == cnt_last) ? 2'h0 : cnt_r + 2'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst || cs_n_s) begin
            op_r <= 8'h00;
        end else if (rx_evt && state_r == ST_CMD && cnt_r == 2'h0) begin
            op_r <= rx_byte;
        end
    end

    // The second octal command byte only completes the command.
    assign kind_nxt = frr_decode((cnt_r == 2'h0) ? rx_byte : op_r);
    // Status and lock reads carry four address bytes only in octal.
    assign needs_addr = (proto != PROTO_SPI) || !(kind_nxt == K_STAT1 ||
                        kind_nxt == K_STAT2 || kind_nxt == K_LOCK);

    // ------------------------------------------------------------------
    // Transaction sequencer
    // ------------------------------------------------------------------
    logic [4:0] lat_cnt_r;
    logic [4:0] lat_sel;
    logic use_nv;
    logic [ADDR_W-1:0] addr_r;
    logic read_active_r;

    always_ff @(posedge clk_sys) begin
        if (rst || cs_n_s) begin
            state_r <= ST_CMD;
        end else begin
            case (state_r)
                ST_CMD: begin
                    if (rx_evt && cnt_r == cnt_last) begin
                        if (kind_nxt == K_NONE) begin
                            state_r <= ST_IGNORE;
                        end else if (needs_addr) begin
                            state_r <= ST_ADDR;
                        end else begin
                            state_r <= ST_LSEL;
                        end
                    end
                end
                ST_ADDR: begin
                    if (rx_evt && cnt_r == ADDR_LAST) begin
                        state_r <= ST_LSEL;
                    end
                end
                ST_LSEL: begin
                    state_r <= (lat_sel == 5'h00) ? ST_DATA : ST_LAT;
                end
                ST_LAT: begin
                    if (rise && lat_cnt_r == 5'h01) begin
                        state_r <= ST_DATA;
                    end
                end
                ST_DATA: state_r <= ST_DATA;
                ST_IGNORE: state_r <= ST_IGNORE;
                default: state_r <= ST_CMD;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst || cs_n_s) begin
            kind_r <= K_NONE;
        end else if (state_r == ST_CMD && rx_evt && cnt_r == cnt_last) begin
            kind_r <= kind_nxt;
        end
    end

    // The address stays fixed for the whole transaction, so repeated
    // clocking rereads the same location.
    always_ff @(posedge clk_sys) begin
        if (rst || cs_n_s) begin
            addr_r <= '0;
        end else if (state_r == ST_ADDR && rx_evt) begin
            addr_r <= {addr_r[ADDR_W-9:0], rx_byte};
        end
    end

    assign use_nv = (kind_r == K_PERS) ||
                    (kind_r == K_GENERIC && !reg_rd_volatile);

    always_comb begin
        if (use_nv) begin
            lat_sel = {1'b0, nonvolatile_latency_config[NV_LAT_MSB:NV_LAT_LSB]};
            if (proto == PROTO_ODDR) begin
                lat_sel = lat_sel + NV_EXTRA_DDR;
            end
        end else begin
            case (proto)
                PROTO_SPI: lat_sel = VOL_LAT_SPI[
                    volatile_latency_config[VOL_LAT_MSB:VOL_LAT_LSB]];
                PROTO_OSDR: lat_sel = VOL_LAT_SDR[
                    volatile_latency_config[VOL_LAT_MSB:VOL_LAT_LSB]];
                default: lat_sel = VOL_LAT_DDR[
                    volatile_latency_config[VOL_LAT_MSB:VOL_LAT_LSB]];
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst || cs_n_s) begin
            lat_cnt_r <= 5'h00;
        end else if (state_r == ST_LSEL) begin
            lat_cnt_r <= lat_sel;
        end else if (state_r == ST_LAT && rise) begin
            lat_cnt_r <= lat_cnt_r - 5'h01;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst || cs_n_s) begin
            read_active_r <= 1'b0;
        end else begin
            read_active_r <= (state_r == ST_LSEL) || (state_r == ST_LAT) ||
                             (state_r == ST_DATA);
        end
    end

    // ------------------------------------------------------------------
    // Data producer into the output buffer
    // ------------------------------------------------------------------
    frr_stream_if #(.W(8)) buf_in ();
    frr_stream_if #(.W(8)) buf_out ();

    frr_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_sys(clk_sys),
        .rst(rst),
        .flush(cs_n_s),
        .wr(buf_in),
        .rd(buf_out)
    );

    logic ecc_sent_r;
    logic produce;
    logic [7:0] src_byte;

    assign produce = (state_r == ST_LAT) || (state_r == ST_DATA);

    always_comb begin
        case (kind_r)
            K_GENERIC: begin
                // Undefined locations simply pass whatever the file returns.
                if (reg_rd_protect_access) begin
                    src_byte = INVALID_BYTE;
                end else if (reg_rd_password &&
                             sector_protect_mode_register == PW_MODE_SEL) begin
                    src_byte = INVALID_BYTE;
                end else begin
                    src_byte = reg_rd_data;
                end
            end
            K_STAT1: src_byte = {volatile_status_one, ready_busy_flag};
            K_STAT2: src_byte = status_two;
            K_LOCK: src_byte = {7'h00, protect_lock_bit};
            K_DYN: src_byte = dynamic_protection_bit;
            K_PERS: src_byte = persistent_protection_bit;
            K_ECC: src_byte = ecc_sent_r ? ECC_FILL : ecc_unit_status;
            default: src_byte = INVALID_BYTE;
        endcase
    end

    // A single-bit status one read only buffers one byte at a time, so
    // each byte shifted out was sampled at most eight host clocks earlier.
    assign buf_in.valid = produce && !(kind_r == K_STAT1 &&
                          proto == PROTO_SPI && buf_out.valid);
    assign buf_in.data = src_byte;

    always_ff @(posedge clk_sys) begin
        if (rst || cs_n_s) begin
            ecc_sent_r <= 1'b0;
        end else if (kind_r == K_ECC && buf_in.valid && buf_in.ready) begin
            ecc_sent_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Output drive and data strobe
    // ------------------------------------------------------------------
    logic [7:0] dq_o_r;
    logic [7:0] dq_oe_r;
    logic ds_o_r;
    logic ds_oe_r;
    logic [7:0] tx_sh_r;
    logic [2:0] tx_bit_r;
    logic [2:0] pd_cnt_r;
    logic drv_evt;
    logic sdr_strobe;
    logic [7:0] out_byte;

    assign drv_evt = (state_r == ST_DATA) &&
                     ((proto == PROTO_ODDR) ? edge_any : fall);
    assign sdr_strobe = (state_r == ST_DATA) && proto == PROTO_OSDR &&
                        rise && dq_oe_r[0];
    assign out_byte = buf_out.valid ? buf_out.data : INVALID_BYTE;
    assign buf_out.ready = drv_evt &&
                           (proto != PROTO_SPI || tx_bit_r == 3'h0);

    always_ff @(posedge clk_sys) begin
        if (rst || cs_n_s) begin
            dq_o_r <= 8'h00;
            dq_oe_r <= 8'h00;
            ds_o_r <= 1'b0;
            tx_sh_r <= 8'h00;
            tx_bit_r <= 3'h0;
        end else if (drv_evt && proto == PROTO_SPI) begin
            dq_oe_r <= SINGLE_OUT_LANE;
            tx_bit_r <= tx_bit_r + 3'h1;
            if (tx_bit_r == 3'h0) begin
                dq_o_r <= {6'h00, out_byte[7], 1'b0};
                tx_sh_r <= {out_byte[6:0], 1'b0};
            end else begin
                dq_o_r <= {6'h00, tx_sh_r[7], 1'b0};
                tx_sh_r <= {tx_sh_r[6:0], 1'b0};
            end
        end else if (drv_evt) begin
            dq_o_r <= out_byte;
            dq_oe_r <= OCTAL_OUT_LANES;
            if (proto == PROTO_ODDR) begin
                ds_o_r <= !ds_o_r;
            end else begin
                ds_o_r <= 1'b0;
            end
        end else if (sdr_strobe) begin
            ds_o_r <= 1'b1;
        end
    end

    // Host edges after the last address byte; five of them are 2.5 clocks.
    always_ff @(posedge clk_sys) begin
        if (rst || cs_n_s || rx_phase) begin
            pd_cnt_r <= 3'h0;
        end else if (edge_any && pd_cnt_r != PREDRIVE_EDGES) begin
            pd_cnt_r <= pd_cnt_r + 3'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst || cs_n_s) begin
            ds_oe_r <= 1'b0;
        end else if (proto != PROTO_SPI && state_r != ST_IGNORE &&
                     !rx_phase && edge_any &&
                     pd_cnt_r == PREDRIVE_EDGES - 3'h1) begin
            ds_oe_r <= 1'b1;
        end else if (proto != PROTO_SPI && drv_evt) begin
            ds_oe_r <= 1'b1;
        end
    end

    assign dq_o = dq_o_r;
    assign dq_oe = dq_oe_r;
    assign ds_o = ds_o_r;
    assign ds_oe = ds_oe_r;
    assign read_addr = addr_r;
    assign read_active = read_active_r;
endmodule
`default_nettype wire

// ### verilog/frr_pkg.sv
`default_nettype none
package frr_pkg;

    // ------------------------------------------------------------------
    // Transfer shape
    // ------------------------------------------------------------------
    localparam int ADDR_W = 32;
    localparam logic [1:0] ADDR_LAST = 2'h3;
    localparam logic [1:0] CMD_LAST_SINGLE = 2'h0;
    localparam logic [1:0] CMD_LAST_OCTAL = 2'h1;
    localparam logic [2:0] SINGLE_LAST_BIT = 3'h7;
    localparam logic [2:0] PREDRIVE_EDGES = 3'h5;
    localparam logic [7:0] SINGLE_OUT_LANE = 8'h02;
    localparam logic [7:0] OCTAL_OUT_LANES = 8'hff;
    localparam logic [7:0] INVALID_BYTE = 8'hff;
    localparam logic [7:0] ECC_FILL = 8'h00;
    localparam logic [2:0] PW_MODE_SEL = 3'h2;

    // ------------------------------------------------------------------
    // Latency fields and lookup
    // ------------------------------------------------------------------
    localparam int NV_LAT_LSB = 0;
    localparam int NV_LAT_MSB = 3;
    localparam int VOL_LAT_LSB = 6;
    localparam int VOL_LAT_MSB = 7;
    localparam logic [4:0] NV_EXTRA_DDR = 5'h04;
    localparam logic [4:0] VOL_LAT_SPI [4] = '{5'h00, 5'h01, 5'h02, 5'h03};
    localparam logic [4:0] VOL_LAT_SDR [4] = '{5'h03, 5'h04, 5'h05, 5'h06};
    localparam logic [4:0] VOL_LAT_DDR [4] = '{5'h04, 5'h05, 5'h06, 5'h07};

    // ------------------------------------------------------------------
    // Opcodes
    // ------------------------------------------------------------------
    localparam logic [7:0] OP_GENERIC_REG_READ_SINGLE = 8'h65;
    localparam logic [7:0] OP_GENERIC_REG_READ_OCTAL = 8'h66;
    localparam logic [7:0] OP_STATUS_ONE_READ_SINGLE = 8'h05;
    localparam logic [7:0] OP_STATUS_ONE_READ_OCTAL = 8'h06;
    localparam logic [7:0] OP_STATUS_TWO_READ_SINGLE = 8'h07;
    localparam logic [7:0] OP_STATUS_TWO_READ_OCTAL = 8'h08;
    localparam logic [7:0] OP_DYNAMIC_PROTECT_READ = 8'he0;
    localparam logic [7:0] OP_PERSISTENT_PROTECT_READ = 8'he2;
    localparam logic [7:0] OP_PERSISTENT_PROTECT_READ_ALT = 8'he3;
    localparam logic [7:0] OP_PROTECT_LOCK_READ_SINGLE = 8'ha7;
    localparam logic [7:0] OP_PROTECT_LOCK_READ_OCTAL = 8'ha8;
    localparam logic [7:0] OP_ECC_UNIT_STATUS_READ = 8'h19;

    typedef enum logic [1:0] {
        PROTO_SPI = 2'h0,
        PROTO_OSDR = 2'h1,
        PROTO_ODDR = 2'h2
    } frr_proto_t;

    typedef enum logic [2:0] {
        K_NONE = 3'h0, K_GENERIC = 3'h1, K_STAT1 = 3'h2, K_STAT2 = 3'h3,
        K_LOCK = 3'h4, K_DYN = 3'h5, K_PERS = 3'h6, K_ECC = 3'h7
    } frr_kind_t;

    typedef enum logic [5:0] {
        ST_CMD = 6'h01, ST_ADDR = 6'h02, ST_LSEL = 6'h04,
        ST_LAT = 6'h08, ST_DATA = 6'h10, ST_IGNORE = 6'h20
    } frr_state_t;

    function automatic frr_kind_t frr_decode(input logic [7:0] op);
        case (op)
            OP_GENERIC_REG_READ_SINGLE, OP_GENERIC_REG_READ_OCTAL:
                frr_decode = K_GENERIC;
            OP_STATUS_ONE_READ_SINGLE, OP_STATUS_ONE_READ_OCTAL:
                frr_decode = K_STAT1;
            OP_STATUS_TWO_READ_SINGLE, OP_STATUS_TWO_READ_OCTAL:
                frr_decode = K_STAT2;
            OP_PROTECT_LOCK_READ_SINGLE, OP_PROTECT_LOCK_READ_OCTAL:
                frr_decode = K_LOCK;
            OP_DYNAMIC_PROTECT_READ: frr_decode = K_DYN;
            OP_PERSISTENT_PROTECT_READ, OP_PERSISTENT_PROTECT_READ_ALT:
                frr_decode = K_PERS;
            OP_ECC_UNIT_STATUS_READ: frr_decode = K_ECC;
            default: frr_decode = K_NONE;
        endcase
    endfunction

endpackage
`default_nettype wire

// ### verilog/frr_stream_if.sv
`timescale 1ns/100ps
`default_nettype none
interface frr_stream_if #(
    parameter int W = 8
);
    logic valid;
    logic ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ### verilog/frr_sync.sv
`timescale 1ns/100ps
`default_nettype none
module frr_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Asynchronous levels in, synchronised levels out
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;
    logic [W-1:0] q_r;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            meta_r <= '0;
            q_r <= '0;
        end else begin
            meta_r <= d;
            q_r <= meta_r;
        end
    end

    assign q = q_r;
endmodule
`default_nettype wire

// ### verilog/frr_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module frr_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Drops all entries
    input wire logic flush,
    // Streams
    frr_stream_if.snk wr,
    frr_stream_if.src rd
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem_r [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] cnt_r;
    logic push;
    logic pop;

    assign wr.ready = (cnt_r != (AW+1)'(DEPTH));
    assign rd.valid = (cnt_r != '0);
    assign rd.data = mem_r[rp_r];
    assign push = wr.valid && wr.ready;
    assign pop = rd.valid && rd.ready;

    for (genvar i = 0; i < DEPTH; i++) begin : g_entry
        always_ff @(posedge clk_sys) begin
            if (rst) begin
                mem_r[i] <= '0;
            end else if (push && wp_r == AW'(i)) begin
                mem_r[i] <= wr.data;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst || flush) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wp_r <= wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= rp_r + 1'b1;
            end
            if (push && !pop) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (pop && !push) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ### tb/frr_checker.sv
`timescale 1ns/100ps
`default_nettype none
module frr_checker
    import frr_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Host side
    input wire logic cs_n,
    input wire logic octal_en,
    input wire logic ddr_en,
    input wire logic [7:0] dq_o,
    input wire logic [7:0] dq_oe,
    input wire logic ds_o,
    input wire logic ds_oe,
    // Register lookup
    input wire logic [ADDR_W-1:0] read_addr,
    input wire logic read_active
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    property p_lanes; dq_oe inside {8'h00, 8'h02, 8'hff}; endproperty
    a_lanes: assert property (p_lanes) else $error("bad enables");
    property p_strobe; dq_oe == 8'hff |-> ds_oe; endproperty
    a_strobe: assert property (p_strobe) else $error("no strobe");
    property p_rel; cs_n [*5] |-> dq_oe == 8'h00 && !ds_oe; endproperty
    a_rel: assert property (p_rel) else $error("not released");
    property p_one; dq_oe == 8'h02 |-> ~|dq_o[7:2] && !dq_o[0]; endproperty
    a_one: assert property (p_one) else $error("bad lane");
    property p_addr;
        read_active && $past(read_active) |-> $stable(read_addr); endproperty
    a_addr: assert property (p_addr) else $error("addr moved");
    property p_sdr; octal_en && !ddr_en && dq_oe == 8'hff && $changed(dq_o)
        |-> !ds_o; endproperty
    a_sdr: assert property (p_sdr) else $error("sdr strobe");
    property p_ddr; ddr_en && dq_oe == 8'hff && $past(dq_oe) == 8'hff
        && $changed(dq_o) |-> $changed(ds_o); endproperty
    a_ddr: assert property (p_ddr) else $error("ddr strobe");
    property p_pre; $rose(ds_oe) |-> read_active; endproperty
    a_pre: assert property (p_pre) else $error("early strobe");
    c_single: cover property (dq_oe == 8'h02);
    c_sdr: cover property (ds_oe && !ddr_en);
    c_ddr: cover property (ds_oe && ddr_en);
endmodule
bind frr_read_path frr_checker i_frr_checker (.clk_sys, .rst, .cs_n,
    .octal_en, .ddr_en, .dq_o, .dq_oe, .ds_o, .ds_oe, .read_addr,
    .read_active);
`default_nettype wire

// ### tb/frr_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module frr_host_model (
    // Clock
    input wire logic clk_sys,
    // Host pins
    output logic cs_n,
    output logic sck,
    output logic [7:0] dq_i,
    // Device answer
    input wire logic [7:0] dq_o,
    input wire logic [7:0] dq_oe
);
    logic [7:0] rx[$];
    int first;
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        dq_i = 8'h00;
    end
    // Answers are sampled one clock after the following edge, so the
    // device's pin-to-output lag never races the capture.
    task automatic run(input int m, input logic [7:0] tx[$], input int n);
        logic [7:0] u[$];
        logic [7:0] sh;
        int nb;
        nb = 0;
        sh = 8'h00;
        rx.delete();
        first = 0;
        foreach (tx[i])
            for (int b = 7; b >= 0; b--)
                if (m == 0) u.push_back({7'h00, tx[i][b]});
                else if (b == 0) u.push_back(tx[i]);
        @(posedge clk_sys);
        cs_n <= 1'b0;
        dq_i <= u.pop_front();
        repeat (4) @(posedge clk_sys);
        for (int e = 0; e < 2 * n; e++) begin
            sck <= ~sck;
            @(posedge clk_sys);
            if (dq_oe != 8'h00 && (m == 2 || e % 2 == 0)) begin
                if (first == 0) first = e / 2 + 1;
                sh = m == 0 ? {sh[6:0], dq_o[1]} : dq_o;
                nb = m == 0 ? nb + 1 : 8;
                if (nb == 8) rx.push_back(sh);
                nb = nb % 8;
            end
            @(posedge clk_sys);
            if (m == 2 || e % 2 == 1)
                dq_i <= u.size() > 0 ? u.pop_front() : ~dq_i;
            repeat (2) @(posedge clk_sys);
        end
        cs_n <= 1'b1;
        repeat (8) @(posedge clk_sys);
    endtask
endmodule
`default_nettype wire

// ### tb/test_flash_register_read_path.sv
`timescale 1ns/100ps
`default_nettype none
module test_flash_register_read_path
    import frr_pkg::*;
;
    logic clk_sys = 1'b0, rst = 1'b1, octal_en = 1'b0, ddr_en = 1'b0;
    logic ready_busy_flag = 1'b1, protect_lock_bit = 1'b1;
    logic cs_n, sck, read_active, ds_o, ds_oe;
    logic [7:0] nonvolatile_latency_config = 8'h02;
    logic [7:0] volatile_latency_config = 8'h40;
    logic [2:0] sector_protect_mode_register = 3'h0;
    logic [7:1] volatile_status_one = 7'h2b;
    logic [7:0] dq_i, dq_o, dq_oe, rx[$], status_two = 8'h3c;
    logic [7:0] dynamic_protection_bit = 8'h4d, ecc_unit_status = 8'h6f;
    logic [7:0] persistent_protection_bit = 8'h5e;
    logic [ADDR_W-1:0] read_addr;
    wire [7:0] reg_rd_data = read_addr[7:0] ^ 8'ha5;
    wire reg_rd_volatile = read_addr[8];
    wire reg_rd_password = read_addr[9];
    wire reg_rd_protect_access = read_addr[10];
    int n_mismatch = 0, check_count = 0, first;
    frr_read_path i_frr_read_path (.clk_sys, .rst, .cs_n, .sck, .dq_i,
        .dq_o, .dq_oe, .ds_o, .ds_oe, .octal_en, .ddr_en,
        .nonvolatile_latency_config, .volatile_latency_config,
        .sector_protect_mode_register, .ready_busy_flag,
        .volatile_status_one, .status_two, .protect_lock_bit,
        .dynamic_protection_bit, .persistent_protection_bit,
        .ecc_unit_status, .read_addr, .read_active, .reg_rd_data,
        .reg_rd_volatile, .reg_rd_password, .reg_rd_protect_access);
    frr_host_model i_frr_host_model (.clk_sys, .cs_n, .sck, .dq_i, .dq_o,
        .dq_oe);
    always #50 clk_sys = ~clk_sys;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rd(input int m, input logic [7:0] op,
        input logic [31:0] a, input logic na, input int n);
        logic [7:0] tx[$];
        tx = {op};
        if (m != 0) tx.push_back(~op);
        if (m != 0 || na) tx = {tx, a[31:24], a[23:16], a[15:8], a[7:0]};
        @(posedge clk_sys);
        octal_en <= m != 0;
        ddr_en <= m == 2;
        i_frr_host_model.run(m, tx, n);
        rx = i_frr_host_model.rx;
        first = i_frr_host_model.first;
    endtask
    task automatic s_generic_single;
        rd(0, OP_GENERIC_REG_READ_SINGLE, 32'h12, 1'b1, 67);
        chk(first, 43);
        for (int i = 0; i < 3; i++) chk(rx[i], 8'hb7);
    endtask
    task automatic s_dedicated;
        logic [7:0] op[8] = '{OP_STATUS_ONE_READ_OCTAL,
            OP_STATUS_TWO_READ_OCTAL, OP_PROTECT_LOCK_READ_OCTAL,
            OP_GENERIC_REG_READ_OCTAL, OP_DYNAMIC_PROTECT_READ,
            OP_PERSISTENT_PROTECT_READ, OP_PERSISTENT_PROTECT_READ_ALT,
            OP_ECC_UNIT_STATUS_READ};
        logic [7:0] ex[8] = '{8'h57, 8'h3c, 8'h01, 8'h95, 8'h4d, 8'h5e,
            8'h5e, 8'h6f};
        for (int i = 0; i < 8; i++) begin
            rd(1, op[i], i < 3 ? 32'h0 : 32'h1130, 1'b1, 14);
            chk(rx[0], ex[i]);
            chk(first, i == 5 || i == 6 ? 9 : VOL_LAT_SDR[1] + 7);
        end
        chk(rx[1], ECC_FILL);
        rd(1, OP_ECC_UNIT_STATUS_READ, 32'h1140, 1'b1, 14);
        chk(rx[0], 8'h6f);
    endtask
    task automatic s_guarded;
        logic [31:0] a[3] = '{32'h200, 32'h400, 32'hff};
        logic [7:0] e[3] = '{8'hff, 8'hff, 8'h5a};
        sector_protect_mode_register <= PW_MODE_SEL;
        for (int i = 0; i < 3; i++) begin
            rd(2, OP_GENERIC_REG_READ_OCTAL, a[i], 1'b1, 14);
            chk(rx[0], e[i]);
            chk(first, NV_EXTRA_DDR + 6);
        end
    endtask
    task automatic s_status_single;
        fork
            rd(0, OP_STATUS_ONE_READ_SINGLE, 32'h0, 1'b0, 34);
            begin
                repeat (120) @(posedge clk_sys);
                ready_busy_flag <= 1'b0;
            end
        join
        chk(first, VOL_LAT_SPI[1] + 9);
        chk(rx[0], 8'h57);
        chk(rx[2], 8'h56);
    endtask
    task automatic tally_and_finish;
        $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (4) @(posedge clk_sys);
        s_generic_single();
        s_dedicated();
        s_guarded();
        s_status_single();
        tally_and_finish();
    end
    initial begin
        repeat (60000) @(posedge clk_sys);
        n_mismatch++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
